// >>> logic/ccrb_top.sv
`timescale 1ns/1ps
`include "ccrb_defs.svh"
module ccrb_top (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // reset pin, low asserts
    input wire logic codec_reset_pin_n,
    // control and DAC words from the serial port
    input wire logic [15:0] ctl_word,
    input wire logic ctl_word_valid,
    // words passed out, echoed or read back
    output logic [15:0] echo_word_r,
    output logic echo_valid_r,
    // DAC words
    output logic [15:0] dac_word_r,
    output logic dac_valid_r,
    // timing
    output logic divided_master_clock,
    output logic serial_clock_tick,
    output logic output_frame_sync_r,
    output logic reset_busy_r,
    // mode register
    output logic operating_mode_select,
    output logic mixed_mode_enable,
    output logic mixed_mode_active_r,
    output logic digital_loopback_enable,
    output logic serial_loopback_enable,
    output logic [2:0] cascade_count,
    // clock register
    output logic [1:0] sample_rate_sel,
    output logic [1:0] serial_clock_divider_sel,
    output logic [2:0] master_divider_sel,
    output logic control_echo_enable,
    // power register
    output logic device_power_on,
    output logic analog_tap_power_on,
    output logic input_amp_power_on,
    output logic adc_power_on,
    output logic dac_power_on,
    output logic reference_power_on,
    output logic reference_output_pin_enable,
    // gain register
    output logic [2:0] input_gain_sel,
    output logic adc_modulator_reset,
    output logic [2:0] output_gain_sel,
    output logic output_mute,
    // DAC timing register
    output logic [4:0] dac_advance,
    output logic interpolator_bypass,
    output logic digital_tap_enable,
    output logic test_mode_enable,
    // analog tap register
    output logic [4:0] analog_tap_coeff,
    output logic single_ended_or_tap_enable,
    output logic input_invert,
    output logic analog_loopback_or_tap_mute,
    // digital tap coefficient
    output logic [15:0] digital_tap_coeff
);
    ccrb_pkg::ccrb_byte_t regs_r [0:7];
    ccrb_pkg::ccrb_rst_state_t rs_r;
    ccrb_pkg::ccrb_rst_state_t rs_nxt;
    logic [1:0] rs_cnt_r;
    logic [10:0] fs_cnt_r;
    logic pin_level_r;
    logic divided_master_clock_tick;
    logic sclk_tick;

    ccrb_pin_sync #(
        .RST_VAL(1'b0)
    ) u_pin_sync (
        .core_clk(core_clk),
        .rst(rst),
        .pin_in(codec_reset_pin_n),
        .level_r(pin_level_r)
    );

    // master divider: 0..4 give over 1..5, other codes undivided
    wire [2:0] mcd = regs_r[`CCRB_REG_CLK][`CCRB_CLK_MCD_HI:`CCRB_CLK_MCD_LO];
    wire [2:0] mcd_limit = (mcd > 3'h4) ? 3'h0 : mcd;

    ccrb_tick_div #(
        .W(3)
    ) u_divided_master_clock_div (
        .core_clk(core_clk),
        .rst(rst),
        .en(1'b1),
        .limit(mcd_limit),
        .tick_r(divided_master_clock_tick)
    );

    wire [1:0] scd = regs_r[`CCRB_REG_CLK][`CCRB_CLK_SCD_HI:`CCRB_CLK_SCD_LO];
    wire [2:0] scd_limit = (scd == 2'h0) ? `CCRB_SCD_DIV8 :
                           (scd == 2'h1) ? `CCRB_SCD_DIV4 :
                           (scd == 2'h2) ? `CCRB_SCD_DIV2 : `CCRB_SCD_DIV1;

    ccrb_tick_div #(
        .W(3)
    ) u_sclk_div (
        .core_clk(core_clk),
        .rst(rst),
        .en(divided_master_clock_tick),
        .limit(scd_limit),
        .tick_r(sclk_tick)
    );

    assign divided_master_clock = divided_master_clock_tick;
    assign serial_clock_tick = sclk_tick;

    // control word decode
    wire pin_low = ~pin_level_r;
    wire [2:0] dev = ctl_word[`CCRB_W_DEV_HI:`CCRB_W_DEV_LO];
    wire [2:0] idx = ctl_word[`CCRB_W_REG_HI:`CCRB_W_REG_LO];
    wire [7:0] data = ctl_word[`CCRB_W_DATA_HI:0];
    wire [2:0] dev_dec = dev - `CCRB_DEV_STEP;
    wire op_mode = regs_r[`CCRB_REG_MODE][`CCRB_MODE_OP];
    wire mm_bit = regs_r[`CCRB_REG_MODE][`CCRB_MODE_MM];
    wire mixed_live = op_mode & mm_bit;
    wire slb_live = regs_r[`CCRB_REG_MODE][`CCRB_MODE_SLB];
    wire cee = regs_r[`CCRB_REG_CLK][`CCRB_CLK_CEE];
    // words are refused while any reset is still running
    wire word_ok = ctl_word_valid & (rs_r == ccrb_pkg::CCRB_RS_IDLE);
    // plain data mode takes no control words; only a reset gets out of it
    wire ctl_allowed = ~op_mode | mixed_live;
    wire is_ctl = word_ok & ctl_word[`CCRB_W_CD] & ctl_allowed;
    wire addr_me = (dev == `CCRB_DEV_SELF);
    wire pass = is_ctl & ~addr_me;
    wire rd = is_ctl & addr_me & ctl_word[`CCRB_W_RW];
    wire wr = is_ctl & addr_me & ~ctl_word[`CCRB_W_RW];
    wire sw_rst_go = wr & (idx == `CCRB_REG_MODE) & data[`CCRB_MODE_SWRST];
    wire clear_regs = pin_low | sw_rst_go;
    // reserved power bit kept at zero even if the host slips
    wire [7:0] wr_data = (idx == `CCRB_REG_PWR) ? {1'b0, data[6:0]} : data;

    always_ff @(posedge core_clk) begin
        for (int i = 0; i < 8; i++) begin
            if (rst || clear_regs) begin
                regs_r[i] <= `CCRB_REG_RESET;
            end else if (wr && (idx == i[2:0])) begin
                regs_r[i] <= wr_data;
            end
        end
    end

    // reset sequencer: pin held low, then four divided clocks
    always_comb begin
        rs_nxt = rs_r;
        unique case (rs_r)
            ccrb_pkg::CCRB_RS_IDLE: begin
                if (sw_rst_go) begin
                    rs_nxt = ccrb_pkg::CCRB_RS_COUNT;
                end
            end
            ccrb_pkg::CCRB_RS_HOLD: begin
                if (!pin_low) begin
                    rs_nxt = ccrb_pkg::CCRB_RS_COUNT;
                end
            end
            ccrb_pkg::CCRB_RS_COUNT: begin
                if (divided_master_clock_tick && rs_cnt_r == `CCRB_RST_LAST) begin
                    rs_nxt = ccrb_pkg::CCRB_RS_IDLE;
                end
            end
        endcase
        if (pin_low) begin
            rs_nxt = ccrb_pkg::CCRB_RS_HOLD;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            rs_r <= ccrb_pkg::CCRB_RS_HOLD;
            rs_cnt_r <= 2'h0;
            reset_busy_r <= 1'b1;
        end else begin
            rs_r <= rs_nxt;
            reset_busy_r <= (rs_nxt != ccrb_pkg::CCRB_RS_IDLE);
            if (rs_r != ccrb_pkg::CCRB_RS_COUNT) begin
                rs_cnt_r <= 2'h0;
            end else if (divided_master_clock_tick) begin
                rs_cnt_r <= rs_cnt_r + `CCRB_RST_STEP;
            end
        end
    end

    // frame sync: counter restarts while the pin is low
    wire [1:0] dir = regs_r[`CCRB_REG_CLK][`CCRB_CLK_DIR_HI:`CCRB_CLK_DIR_LO];
    wire [10:0] fs_limit = (dir == 2'h0) ? `CCRB_FS_P2048 :
                           (dir == 2'h1) ? `CCRB_FS_P1024 :
                           (dir == 2'h2) ? `CCRB_FS_P512 : `CCRB_FS_P256;
    // >= so that a faster rate programmed mid-period wraps at once
    wire fs_wrap = divided_master_clock_tick & (fs_cnt_r >= fs_limit);

    always_ff @(posedge core_clk) begin
        if (rst || pin_low) begin
            fs_cnt_r <= 11'h000;
            output_frame_sync_r <= 1'b0;
        end else begin
            output_frame_sync_r <= fs_wrap;
            if (fs_wrap) begin
                fs_cnt_r <= 11'h000;
            end else if (divided_master_clock_tick) begin
                fs_cnt_r <= fs_cnt_r + `CCRB_FS_STEP;
            end
        end
    end

    // echo path: pass-on, read-back, control echo, serial loopback
    wire echo_go = (word_ok & slb_live) | pass | rd | (wr & cee);
    wire [15:0] echo_nxt = (word_ok & slb_live) ? ctl_word :
                           pass ? {ctl_word[`CCRB_W_CD:`CCRB_W_RW], dev_dec, ctl_word[10:0]} :
                           rd ? {ctl_word[15:8], regs_r[idx]} : ctl_word;
    // DAC path; program-mode data words are dropped
    wire dac_plain = op_mode & ~mm_bit;
    wire dac_go = word_ok & (dac_plain | (mixed_live & ~ctl_word[`CCRB_W_CD]));
    wire [15:0] dac_nxt = mixed_live ? {ctl_word[`CCRB_W_DAC_HI:0], 1'b0} : ctl_word;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            echo_word_r <= 16'h0000;
            echo_valid_r <= 1'b0;
            dac_word_r <= 16'h0000;
            dac_valid_r <= 1'b0;
            mixed_mode_active_r <= 1'b0;
        end else begin
            echo_valid_r <= echo_go;
            dac_valid_r <= dac_go;
            mixed_mode_active_r <= mixed_live & ~clear_regs;
            if (echo_go) begin
                echo_word_r <= echo_nxt;
            end
            if (dac_go) begin
                dac_word_r <= dac_nxt;
            end
        end
    end

    // register fields
    assign operating_mode_select = regs_r[`CCRB_REG_MODE][`CCRB_MODE_OP];
    assign mixed_mode_enable = regs_r[`CCRB_REG_MODE][`CCRB_MODE_MM];
    assign digital_loopback_enable = regs_r[`CCRB_REG_MODE][`CCRB_MODE_DLB];
    assign serial_loopback_enable = regs_r[`CCRB_REG_MODE][`CCRB_MODE_SLB];
    assign cascade_count = regs_r[`CCRB_REG_MODE][`CCRB_MODE_DC_HI:`CCRB_MODE_DC_LO];
    assign sample_rate_sel = dir;
    assign serial_clock_divider_sel = scd;
    assign master_divider_sel = mcd;
    assign control_echo_enable = cee;
    assign device_power_on = regs_r[`CCRB_REG_PWR][`CCRB_PWR_PU];
    assign analog_tap_power_on = regs_r[`CCRB_REG_PWR][`CCRB_PWR_AGT];
    assign input_amp_power_on = regs_r[`CCRB_REG_PWR][`CCRB_PWR_IA];
    assign adc_power_on = regs_r[`CCRB_REG_PWR][`CCRB_PWR_ADC];
    assign dac_power_on = regs_r[`CCRB_REG_PWR][`CCRB_PWR_DAC];
    assign reference_power_on = regs_r[`CCRB_REG_PWR][`CCRB_PWR_REF];
    assign reference_output_pin_enable = regs_r[`CCRB_REG_PWR][`CCRB_PWR_RU];
    assign input_gain_sel = regs_r[`CCRB_REG_GAIN][`CCRB_GAIN_IGS_HI:0];
    assign adc_modulator_reset = regs_r[`CCRB_REG_GAIN][`CCRB_GAIN_ADC_MODULATOR_RESET];
    assign output_gain_sel = regs_r[`CCRB_REG_GAIN][`CCRB_GAIN_OGS_HI:`CCRB_GAIN_OGS_LO];
    assign output_mute = regs_r[`CCRB_REG_GAIN][`CCRB_GAIN_MUTE];
    assign dac_advance = regs_r[`CCRB_REG_DAC][`CCRB_DAC_DA_HI:0];
    assign interpolator_bypass = regs_r[`CCRB_REG_DAC][`CCRB_DAC_INTERPOLATOR_BYPASS];
    assign digital_tap_enable = regs_r[`CCRB_REG_DAC][`CCRB_DAC_DIGITAL_TAP_ENABLE];
    assign test_mode_enable = regs_r[`CCRB_REG_DAC][`CCRB_DAC_TME];
    assign analog_tap_coeff = regs_r[`CCRB_REG_ATAP][`CCRB_ATAP_C_HI:0];
    assign single_ended_or_tap_enable = regs_r[`CCRB_REG_ATAP][`CCRB_ATAP_SEEN];
    assign input_invert = regs_r[`CCRB_REG_ATAP][`CCRB_ATAP_INV];
    assign analog_loopback_or_tap_mute = regs_r[`CCRB_REG_ATAP][`CCRB_ATAP_ALB];
    assign digital_tap_coeff = {regs_r[`CCRB_REG_DTAP_HI], regs_r[`CCRB_REG_DTAP_LO]};

    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);

    sequence s_mode_write;
        wr && !pin_low && idx == `CCRB_REG_MODE && !data[`CCRB_MODE_SWRST];
    endsequence

    sequence s_loop_word;
        word_ok && slb_live;
    endsequence

    sequence s_mixed_dac;
        word_ok && mixed_live && !ctl_word[`CCRB_W_CD];
    endsequence

    sequence s_pin_release;
        pin_low ##1 !pin_low;
    endsequence

    sequence s_sw_reset;
        sw_rst_go && !pin_low;
    endsequence

    a_mode_bit_write: assert property (s_mode_write |=> operating_mode_select == $past(data[0]))
        else $error("mode bit did not take the written value");
    a_swrst_self_clear: assert property (sw_rst_go |=> regs_r[`CCRB_REG_MODE] == 8'h00 && reset_busy_r)
        else $error("software reset did not clear the mode register");
    a_pwr_reserved_zero: assert property (regs_r[`CCRB_REG_PWR][`CCRB_PWR_RSVD] == 1'b0)
        else $error("reserved power bit is set");
    a_pin_clears_regs: assert property (pin_low |=> digital_tap_coeff == 16'h0000 && !operating_mode_select)
        else $error("reset pin left a register set");
    a_reset_four_ticks: assert property ($fell(reset_busy_r) |-> $past(divided_master_clock_tick) && $past(rs_cnt_r) == 2'h3)
        else $error("reset ended without four divided clocks");
    a_mixed_needs_both: assert property (mixed_mode_active_r |-> $past(op_mode) && $past(mm_bit))
        else $error("mixed mode active without both bits");
    a_frame_sync_period: assert property (output_frame_sync_r |-> $past(fs_cnt_r) >= $past(fs_limit))
        else $error("frame sync before the period count");
    a_pass_decrement: assert property (pass && !slb_live |=>
        echo_valid_r && echo_word_r[13:11] == $past(dev) - 3'h1)
        else $error("passed word not decremented");
    a_refuse_in_reset: assert property (reset_busy_r && ctl_word_valid && !slb_live |=> !echo_valid_r)
        else $error("word taken while reset runs");
    a_sclk_default: assert property (sclk_tick && scd == 2'h0 && $past(scd) == 2'h0 |-> !$past(sclk_tick))
        else $error("default serial clock too fast");

    a_read_returns_reg: assert property (rd && !slb_live |=> echo_word_r[7:0] == $past(regs_r[idx]))
        else $error("read-back byte differs from the register");
    a_write_echo: assert property (wr && cee && !slb_live |=> echo_valid_r && echo_word_r == $past(ctl_word))
        else $error("control echo missing or altered");
    a_loop_echo: assert property (s_loop_word |=> echo_valid_r && echo_word_r == $past(ctl_word))
        else $error("loopback word not returned unchanged");
    a_mixed_dac: assert property (s_mixed_dac |=> dac_valid_r && dac_word_r == {$past(ctl_word[14:0]), 1'b0})
        else $error("mixed mode DAC word not shifted");
    a_plain_dac: assert property (word_ok && dac_plain |=> dac_valid_r && dac_word_r == $past(ctl_word))
        else $error("data mode word not passed to the DAC");
    a_program_no_dac: assert property (word_ok && !op_mode |=> !dac_valid_r)
        else $error("program mode sent a DAC word");
    a_data_mode_lock: assert property (word_ok && dac_plain && !pin_low |=> $stable(operating_mode_select))
        else $error("data mode accepted a control word");
    a_busy_while_pin: assert property (pin_low |=> reset_busy_r)
        else $error("reset pin low without busy");
    a_busy_after_pin: assert property (s_pin_release |-> reset_busy_r ##1 reset_busy_r)
        else $error("reset ended on pin release");
    a_swrst_busy_four: assert property (s_sw_reset |=> reset_busy_r [*4])
        else $error("software reset shorter than four divided clocks");
    a_busy_no_write: assert property (ctl_word_valid && reset_busy_r && !pin_low |=>
        $stable(operating_mode_select))
        else $error("word written while reset runs");
    a_fs_held_low: assert property (pin_low |=> !output_frame_sync_r)
        else $error("frame sync while the reset pin is low");
    a_fs_restarts: assert property (output_frame_sync_r |-> fs_cnt_r == 11'h000)
        else $error("frame counter not restarted");
    a_mixed_goes_live: assert property (mixed_live && !clear_regs |=> mixed_mode_active_r)
        else $error("mixed mode not active with both bits set");
    a_swrst_reads_zero: assert property (regs_r[`CCRB_REG_MODE][`CCRB_MODE_SWRST] == 1'b0)
        else $error("software reset bit reads back as one");
    a_write_lands: assert property (wr && !clear_regs |=> regs_r[$past(idx)] == $past(wr_data))
        else $error("register write did not land");
endmodule

// >>> pkg/ccrb_defs.svh
`ifndef CCRB_DEFS_SVH
`define CCRB_DEFS_SVH

`define CCRB_REG_MODE 3'h0
`define CCRB_REG_CLK 3'h1
`define CCRB_REG_PWR 3'h2
`define CCRB_REG_GAIN 3'h3
`define CCRB_REG_DAC 3'h4
`define CCRB_REG_ATAP 3'h5
`define CCRB_REG_DTAP_LO 3'h6
`define CCRB_REG_DTAP_HI 3'h7
`define CCRB_REG_RESET 8'h00

`define CCRB_W_CD 15
`define CCRB_W_RW 14
`define CCRB_W_DEV_HI 13
`define CCRB_W_DEV_LO 11
`define CCRB_W_REG_HI 10
`define CCRB_W_REG_LO 8
`define CCRB_W_DATA_HI 7
`define CCRB_W_DAC_HI 14
`define CCRB_DEV_SELF 3'h0
`define CCRB_DEV_STEP 3'h1

`define CCRB_MODE_OP 0
`define CCRB_MODE_MM 1
`define CCRB_MODE_DLB 2
`define CCRB_MODE_SLB 3
`define CCRB_MODE_DC_LO 4
`define CCRB_MODE_DC_HI 6
`define CCRB_MODE_SWRST 7

`define CCRB_CLK_DIR_LO 0
`define CCRB_CLK_DIR_HI 1
`define CCRB_CLK_SCD_LO 2
`define CCRB_CLK_SCD_HI 3
`define CCRB_CLK_MCD_LO 4
`define CCRB_CLK_MCD_HI 6
`define CCRB_CLK_CEE 7

`define CCRB_PWR_PU 0
`define CCRB_PWR_AGT 1
`define CCRB_PWR_IA 2
`define CCRB_PWR_ADC 3
`define CCRB_PWR_DAC 4
`define CCRB_PWR_REF 5
`define CCRB_PWR_RU 6
`define CCRB_PWR_RSVD 7

`define CCRB_GAIN_IGS_HI 2
`define CCRB_GAIN_ADC_MODULATOR_RESET 3
`define CCRB_GAIN_OGS_LO 4
`define CCRB_GAIN_OGS_HI 6
`define CCRB_GAIN_MUTE 7

`define CCRB_DAC_DA_HI 4
`define CCRB_DAC_INTERPOLATOR_BYPASS 5
`define CCRB_DAC_DIGITAL_TAP_ENABLE 6
`define CCRB_DAC_TME 7

`define CCRB_ATAP_C_HI 4
`define CCRB_ATAP_SEEN 5
`define CCRB_ATAP_INV 6
`define CCRB_ATAP_ALB 7

`define CCRB_RST_LAST 2'h3
`define CCRB_RST_STEP 2'h1
`define CCRB_FS_STEP 11'h001
`define CCRB_FS_P2048 11'h7FF
`define CCRB_FS_P1024 11'h3FF
`define CCRB_FS_P512 11'h1FF
`define CCRB_FS_P256 11'h0FF
`define CCRB_SCD_DIV8 3'h7
`define CCRB_SCD_DIV4 3'h3
`define CCRB_SCD_DIV2 3'h1
`define CCRB_SCD_DIV1 3'h0
`endif

// >>> pkg/ccrb_pkg.sv
package ccrb_pkg;
    typedef logic [7:0] ccrb_byte_t;
    typedef enum logic [1:0] {
        CCRB_RS_IDLE,
        CCRB_RS_HOLD,
        CCRB_RS_COUNT
    } ccrb_rst_state_t;
endpackage

// >>> logic/ccrb_pin_sync.sv
`timescale 1ns/1ps
module ccrb_pin_sync #(
    parameter logic RST_VAL = 1'b0
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // pin and filtered level
    input wire logic pin_in,
    output logic level_r
);
    logic s1_r;
    logic s2_r;
    logic s3_r;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            s1_r <= RST_VAL;
            s2_r <= RST_VAL;
            s3_r <= RST_VAL;
            level_r <= RST_VAL;
        end else begin
            s1_r <= pin_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
            // a change is accepted only once stages two and three agree
            if (s2_r == s3_r) begin
                level_r <= s3_r;
            end
        end
    end
endmodule

// >>> logic/ccrb_tick_div.sv
`timescale 1ns/1ps
module ccrb_tick_div #(
    parameter int W = 3
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // input rate and terminal count
    input wire logic en,
    input wire logic [W-1:0] limit,
    // one pulse per limit+1 enables
    output logic tick_r
);
    logic [W-1:0] cnt_r;
    wire wrap = en && (cnt_r >= limit);

    always_ff @(posedge core_clk) begin
        if (rst) begin
            cnt_r <= '0;
            tick_r <= 1'b0;
        end else begin
            tick_r <= wrap;
            if (wrap) begin
                cnt_r <= '0;
            end else if (en) begin
                cnt_r <= cnt_r + {{(W-1){1'b0}}, 1'b1};
            end
        end
    end
endmodule

// >>> test/ccrb_dsp_port.sv
`timescale 1ns/1ps
module ccrb_dsp_port (
    // clock and codec status
    input wire logic core_clk,
    input wire logic reset_busy_r,
    input wire logic slow,
    // words toward the codec
    output logic [15:0] ctl_word,
    output logic ctl_word_valid
);
    initial begin
        ctl_word = 16'h0000;
        ctl_word_valid = 1'b0;
    end

    task automatic send(input logic [15:0] w);
        int i;
        logic [15:0] v;
        i = 0;
        v = w;
        @(negedge core_clk);
        while (reset_busy_r !== 1'b0 && i < 20000) begin
            @(negedge core_clk);
            i++;
        end
        // reserved power bit goes out as zero on writes to device 0's power register
        if (v[15:14] == 2'h2 && v[13:8] == 6'h02) v[7] = 1'b0;
        ctl_word = v;
        ctl_word_valid = 1'b1;
        @(negedge core_clk);
        ctl_word_valid = 1'b0;
        // released port must not look like a held word
        ctl_word = ~v;
        if (slow) repeat (5) @(negedge core_clk);
    endtask
endmodule

// >>> test/tb.sv
`timescale 1ns/1ps
module tb;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic codec_reset_pin_n = 1'b0;
    logic slow = 1'b0;
    logic [15:0] ctl_word, echo_word_r, dac_word_r, digital_tap_coeff, last_echo, q;
    logic ctl_word_valid, echo_valid_r, dac_valid_r, divided_master_clock, serial_clock_tick;
    logic output_frame_sync_r, reset_busy_r, operating_mode_select, mixed_mode_enable, mixed_mode_active_r;
    logic digital_loopback_enable, serial_loopback_enable, control_echo_enable, device_power_on;
    logic analog_tap_power_on, input_amp_power_on, adc_power_on, dac_power_on, reference_power_on;
    logic reference_output_pin_enable, adc_modulator_reset, output_mute, interpolator_bypass, digital_tap_enable;
    logic test_mode_enable, single_ended_or_tap_enable, input_invert, analog_loopback_or_tap_mute;
    logic [2:0] cascade_count, master_divider_sel, input_gain_sel, output_gain_sel;
    logic [1:0] sample_rate_sel, serial_clock_divider_sel;
    logic [4:0] dac_advance, analog_tap_coeff;
    int bad_count = 0, checks_done = 0, cyc = 0, echo_n = 0, dac_n = 0;
    int pin_cyc, fs_first = 0, fs_last, fs_gap, sc_last, sc_gap, dm_last, dm_gap, i, n0;
    // write data beside expected readback, row index is the register
    logic [15:0] rows [8] = '{16'h7676, 16'h8F8F, 16'hFF7F, 16'h5A5A, 16'hC3C3, 16'h9E9E, 16'h3434, 16'hB2B2};

    ccrb_top uut (
        .core_clk, .rst, .codec_reset_pin_n, .ctl_word, .ctl_word_valid, .echo_word_r, .echo_valid_r,
        .dac_word_r, .dac_valid_r, .divided_master_clock, .serial_clock_tick, .output_frame_sync_r,
        .reset_busy_r, .operating_mode_select, .mixed_mode_enable, .mixed_mode_active_r,
        .digital_loopback_enable, .serial_loopback_enable, .cascade_count, .sample_rate_sel,
        .serial_clock_divider_sel, .master_divider_sel, .control_echo_enable, .device_power_on,
        .analog_tap_power_on, .input_amp_power_on, .adc_power_on, .dac_power_on, .reference_power_on,
        .reference_output_pin_enable, .input_gain_sel, .adc_modulator_reset, .output_gain_sel, .output_mute,
        .dac_advance, .interpolator_bypass, .digital_tap_enable, .test_mode_enable, .analog_tap_coeff,
        .single_ended_or_tap_enable, .input_invert, .analog_loopback_or_tap_mute, .digital_tap_coeff
    );

    ccrb_dsp_port u_dsp (.core_clk, .reset_busy_r, .slow, .ctl_word, .ctl_word_valid);

    always #2 core_clk = ~core_clk;

    // pulse trackers, sampled before the edge's own updates land
    always @(posedge core_clk) begin
        cyc++;
        if (echo_valid_r === 1'b1) begin
            echo_n++;
            last_echo = echo_word_r;
        end
        if (dac_valid_r === 1'b1) dac_n++;
        if (output_frame_sync_r === 1'b1) begin
            if (fs_first == 0) fs_first = cyc;
            fs_gap = cyc - fs_last;
            fs_last = cyc;
        end
        if (serial_clock_tick === 1'b1) begin
            sc_gap = cyc - sc_last;
            sc_last = cyc;
        end
        if (divided_master_clock === 1'b1) begin
            dm_gap = cyc - dm_last;
            dm_last = cyc;
        end
    end

    function automatic logic [7:0] view(input logic [2:0] r);
        case (r)
            3'h0: view = {1'b0, cascade_count, serial_loopback_enable, digital_loopback_enable,
                          mixed_mode_enable, operating_mode_select};
            3'h1: view = {control_echo_enable, master_divider_sel, serial_clock_divider_sel, sample_rate_sel};
            3'h2: view = {1'b0, reference_output_pin_enable, reference_power_on, dac_power_on, adc_power_on,
                          input_amp_power_on, analog_tap_power_on, device_power_on};
            3'h3: view = {output_mute, output_gain_sel, adc_modulator_reset, input_gain_sel};
            3'h4: view = {test_mode_enable, digital_tap_enable, interpolator_bypass, dac_advance};
            3'h5: view = {analog_loopback_or_tap_mute, input_invert, single_ended_or_tap_enable, analog_tap_coeff};
            3'h6: view = digital_tap_coeff[7:0];
            default: view = digital_tap_coeff[15:8];
        endcase
    endfunction

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic complete_run;
        if (bad_count == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic idle(input int n);
        repeat (n) @(negedge core_clk);
    endtask

    task automatic wr(input logic [2:0] r, input logic [7:0] d);
        u_dsp.send({5'b10000, r, d});
        idle(3);
    endtask

    // send one word and wait for whatever comes back out
    task automatic xfer(input logic [15:0] w, output logic [15:0] got);
        int k;
        k = 0;
        n0 = echo_n;
        u_dsp.send(w);
        while (echo_n == n0 && k < 20) begin
            idle(1);
            k++;
        end
        got = (echo_n == n0) ? 16'hXXXX : last_echo;
    endtask

    initial begin
        #100000;
        bad_count++;
        complete_run;
    end

    initial begin
        idle(2);
        rst = 1'b0;
        idle(3);
        codec_reset_pin_n = 1'b1;
        pin_cyc = cyc;
        for (i = 0; i < 3000 && fs_first == 0; i++) idle(1);
        chk(16'(fs_first - pin_cyc >= 2048 && fs_first - pin_cyc <= 2060), 16'h0001);
        idle(2100);
        chk(16'(fs_gap), 16'h0800);
        chk(16'(sc_gap), 16'h0008);
        for (i = 0; i < 8; i++) begin
            n0 = echo_n;
            wr(i[2:0], rows[i][15:8]);
            chk({8'h00, view(i[2:0])}, {8'h00, rows[i][7:0]});
            chk({15'h0, reset_busy_r}, 16'h0000);
            if (i != 1) chk(16'(echo_n - n0), (i > 1) ? 16'h0001 : 16'h0000);
            xfer({5'b11000, i[2:0], 8'h00}, q);
            chk(q, {5'b11000, i[2:0], rows[i][7:0]});
        end
        for (i = 0; i < 4; i++) begin
            wr(3'h1, {4'h0, i[1:0], 2'h3});
            idle(30);
            chk(16'(sc_gap), 16'(8 >> i));
        end
        idle(600);
        chk(16'(fs_gap), 16'h0100);
        wr(3'h1, 8'h2F);
        idle(20);
        chk(16'(dm_gap), 16'h0003);
        wr(3'h1, 8'h5F);
        idle(20);
        chk(16'(dm_gap), 16'h0001);
        u_dsp.send(16'h8080);
        n0 = 0;
        for (i = 0; i < 30; i++) begin
            n0 += (reset_busy_r === 1'b1);
            idle(1);
        end
        chk(16'(n0 >= 4 && n0 <= 6), 16'h0001);
        for (i = 0; i < 8; i++) chk({8'h00, view(i[2:0])}, 16'h0000);
        xfer(16'hC000, q);
        chk(q, 16'hC000);
        wr(3'h0, 8'h02);
        chk({15'h0, mixed_mode_active_r}, 16'h0000);
        wr(3'h0, 8'h03);
        chk({15'h0, mixed_mode_active_r}, 16'h0001);
        slow = 1'b1;
        n0 = dac_n;
        u_dsp.send(16'h1235);
        idle(3);
        chk(dac_word_r, 16'h246A);
        chk(16'(dac_n - n0), 16'h0001);
        wr(3'h3, 8'h11);
        chk({8'h00, view(3'h3)}, 16'h0011);
        wr(3'h0, 8'h01);
        u_dsp.send(16'h8123);
        idle(3);
        chk(dac_word_r, 16'h8123);
        chk({8'h00, view(3'h0)}, 16'h0001);
        slow = 1'b0;
        codec_reset_pin_n = 1'b0;
        idle(10);
        chk({15'h0, reset_busy_r}, 16'h0001);
        chk({14'h0, operating_mode_select, mixed_mode_active_r}, 16'h0000);
        for (i = 0; i < 8; i++) chk({8'h00, view(i[2:0])}, 16'h0000);
        codec_reset_pin_n = 1'b1;
        n0 = dac_n;
        u_dsp.send(16'h1234);
        idle(3);
        chk(16'(dac_n - n0), 16'h0000);
        xfer(16'h9345, q);
        chk(q, 16'h8B45);
        chk({8'h00, view(3'h3)}, 16'h0000);
        wr(3'h0, 8'h08);
        xfer(16'hC512, q);
        chk(q, 16'hC512);
        complete_run;
    end
endmodule
